// File: inc/rcs_map.vh
// constants for the reset cause and sequencer block
// Functional notes
// - config mismatch reset sets bit 9 of cause register; else only a software write sets it.
// - bit 8 one keeps regulator active in sleep; zero puts it in standby.
// - master clear pin reset sets pin reset flag, bit 7.
// - executing the reset instruction sets soft reset flag, bit 6.
// - bit 5 enables watchdog; fuse enable forces watchdog on regardless.
// - watchdog time-out sets bit 4.
// - sleep entry sets bit 3; idle entry sets bit 2.
// - brown-out sets bit 1; value one after power-on.
// - power-on sets bit 0; value one after power-on.
// - software may set or clear bits 15, 14 and 9 to 0; bits 13 to 10 stay zero; writes never cause a reset.
// - cold reset takes clock source from initial oscillator select field.
// - warm reset keeps the current oscillator select.
// - crystal and secondary modes count 1024 oscillator clocks before ready.
// - PLL modes also wait the PLL lock time before ready.
// - after brown-out, power-up timer holds reset; then release system reset.
// - three-bit field selects one of eight power-up delays, 0 to 128 ms.
// - once clock ready, execution starts at address 0x000000.
// - clock monitor starts only after clock ready plus its start delay.
// - power-on reset extends 30 us after threshold crossing.
// - each brown-out recovery restarts extension plus power-up delay.
// - low master clear pin requests reset; device filters short glitches.
// - system reset asserts whenever any reset source is active.
// - power-on clears every cause flag except the power-on and brown-out flags, which set.
`ifndef RCS_MAP_VH
`define RCS_MAP_VH
`define RCS_ADDR_CAUSE 4'h0
`define RCS_ADDR_OSC 4'h1
`define RCS_ADDR_STAT 4'h2
`define RCS_B_TRAP 15
`define RCS_B_ILL 14
`define RCS_B_CM 9
`define RCS_B_VREG 8
`define RCS_B_EXT 7
`define RCS_B_SW 6
`define RCS_B_WDEN 5
`define RCS_B_WATCHDOG_TIMEOUT_FLAG 4
`define RCS_B_SLP 3
`define RCS_B_IDL 2
`define RCS_B_BOR 1
`define RCS_B_POR 0
`define RCS_CAUSE_MASK 16'hC3FF
`define RCS_CAUSE_POR_VAL 16'h0003
`define RCS_BOR_KEEP 16'h01A0
`define RCS_CLK_MHZ 200
`define RCS_TOST_CLKS 1024
`define RCS_PLL_LOCK_TIME_US 1500
`define RCS_POWERON_EXTENSION_DELAY_US 30
`define RCS_BROWNOUT_EXTENSION_DELAY_US 100
`define RCS_CLOCK_MONITOR_START_DELAY_US 900
`define RCS_POWERUP_DELAY_MAX_MS 128
`define RCS_RESET_VECTOR 24'h000000
`define RCS_MODE_EC 3'h0
`define RCS_MODE_XT 3'h1
`define RCS_MODE_SOSC 3'h2
`define RCS_MODE_XTPLL 3'h3
`define RCS_MODE_ECPLL 3'h4
`endif

// File: rtl/rcs_reset_seq.v
// reset cause register and reset release sequencer
`timescale 1ns/1ps
`include "rcs_map.vh"
module rcs_reset_seq #(
  parameter integer POWERON_EXTENSION_DELAY_CYC = `RCS_POWERON_EXTENSION_DELAY_US * `RCS_CLK_MHZ,
  parameter integer BROWNOUT_EXTENSION_DELAY_CYC = `RCS_BROWNOUT_EXTENSION_DELAY_US * `RCS_CLK_MHZ,
  parameter integer PLL_LOCK_TIME_CYC = `RCS_PLL_LOCK_TIME_US * `RCS_CLK_MHZ,
  parameter integer CLOCK_MONITOR_START_DELAY_CYC = `RCS_CLOCK_MONITOR_START_DELAY_US * `RCS_CLK_MHZ,
  parameter integer POWERUP_TIMER_UNIT_CYC = 1000 * `RCS_CLK_MHZ,
  parameter integer MASTER_CLEAR_PIN_FILT_CYC = 4
) (
  // clock and power-on reset
  input wire ref_clk,
  input wire rst,
  // supply monitor and reset sources
  input wire brownout_low,
  input wire master_clear_pin_n,
  input wire soft_reset_req,
  input wire watchdog_timeout,
  input wire config_mismatch,
  input wire trap_conflict,
  input wire illegal_condition,
  input wire sleep_entry,
  input wire idle_entry,
  // configuration
  input wire [2:0] initial_osc_select,
  input wire [2:0] powerup_delay_select,
  input wire watchdog_fuse_enable,
  input wire clock_monitor_enable,
  input wire osc_tick,
  // register port
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // outputs
  output wire system_reset_line,
  output reg [2:0] current_osc_select,
  output wire watchdog_enable,
  output wire regulator_active_in_sleep,
  output reg fetch_start,
  output reg [23:0] fetch_addr,
  output reg clock_monitor_active
);
  localparam [5:0] S_POR = 6'h01;
  localparam [5:0] S_BOR = 6'h02;
  localparam [5:0] S_POWERUP_TIMER = 6'h04;
  localparam [5:0] S_OST = 6'h08;
  localparam [5:0] S_LOCK = 6'h10;
  localparam [5:0] S_RUN = 6'h20;

  // sequencer
  reg [5:0] state_q;
  reg [5:0] state_d;
  reg [31:0] cnt_q;
  reg [31:0] cnt_d;
  reg warm_q;
  reg warm_d;
  reg [2:0] osc_d;
  reg fetch_start_d;
  reg [2:0] osc_sel;
  reg [31:0] powerup_timer_cyc;
  reg is_pll;
  reg is_xtal;
  // cause register
  reg [15:0] cause_q;
  wire [15:0] cause_d;
  wire [15:0] hw_set;
  wire [15:0] cause_mask = `RCS_CAUSE_MASK;
  wire [15:0] bor_keep = `RCS_BOR_KEEP;
  // pin filter
  reg master_clear_pin_s1_q;
  reg master_clear_pin_s2_q;
  reg [7:0] master_clear_pin_cnt_q;
  reg [7:0] master_clear_pin_cnt_d;
  reg master_clear_pin_rst_q;
  reg master_clear_pin_rst_d;
  // clock monitor and read path
  reg [31:0] fail_safe_clock_monitor_q;
  reg [31:0] fail_safe_clock_monitor_d;
  reg fail_safe_clock_monitor_active_d;
  reg [15:0] rdata_d;

  // warm sources; the pin held low holds reset too
  wire warm_src = master_clear_pin_rst_q | soft_reset_req | watchdog_timeout | config_mismatch |
    trap_conflict | illegal_condition;
  wire is_write = reg_wr && reg_addr == `RCS_ADDR_CAUSE;

  // a falling supply must pull the line at once, not a cycle later
  assign system_reset_line = (state_q != S_RUN) | warm_src | brownout_low;
  assign watchdog_enable = watchdog_fuse_enable | cause_q[`RCS_B_WDEN];
  assign regulator_active_in_sleep = cause_q[`RCS_B_VREG];

  // eight settings: 0, then doubling up to 128 ms
  always @* begin
    case (powerup_delay_select)
      3'h0: begin
        powerup_timer_cyc = 32'h0;
      end
      3'h1: begin
        powerup_timer_cyc = POWERUP_TIMER_UNIT_CYC * 2;
      end
      3'h2: begin
        powerup_timer_cyc = POWERUP_TIMER_UNIT_CYC * 4;
      end
      3'h3: begin
        powerup_timer_cyc = POWERUP_TIMER_UNIT_CYC * 8;
      end
      3'h4: begin
        powerup_timer_cyc = POWERUP_TIMER_UNIT_CYC * 16;
      end
      3'h5: begin
        powerup_timer_cyc = POWERUP_TIMER_UNIT_CYC * 32;
      end
      3'h6: begin
        powerup_timer_cyc = POWERUP_TIMER_UNIT_CYC * 64;
      end
      3'h7: begin
        powerup_timer_cyc = POWERUP_TIMER_UNIT_CYC * 128;
      end
      default: begin
        powerup_timer_cyc = 32'h0;
      end
    endcase
  end

  always @* begin
    osc_sel = warm_q ? current_osc_select : initial_osc_select;
  end

  // delays each mode needs before its clock counts as ready
  always @* begin
    is_pll = 1'b0;
    is_xtal = 1'b0;
    case (osc_sel)
      `RCS_MODE_EC: begin
        is_pll = 1'b0;
        is_xtal = 1'b0;
      end
      `RCS_MODE_XT: begin
        is_pll = 1'b0;
        is_xtal = 1'b1;
      end
      `RCS_MODE_SOSC: begin
        is_pll = 1'b0;
        is_xtal = 1'b1;
      end
      `RCS_MODE_XTPLL: begin
        is_pll = 1'b1;
        is_xtal = 1'b1;
      end
      `RCS_MODE_ECPLL: begin
        is_pll = 1'b1;
        is_xtal = 1'b0;
      end
      default: begin
        is_pll = 1'b0;
        is_xtal = 1'b0;
      end
    endcase
  end

  // two-flop sync then width filter; count parks once the reset is taken
  always @* begin
    master_clear_pin_cnt_d = master_clear_pin_cnt_q;
    master_clear_pin_rst_d = master_clear_pin_rst_q;
    if (master_clear_pin_s2_q) begin
      master_clear_pin_cnt_d = 8'h00;
      master_clear_pin_rst_d = 1'b0;
    end else if (master_clear_pin_cnt_q == MASTER_CLEAR_PIN_FILT_CYC[7:0]) begin
      master_clear_pin_rst_d = 1'b1;
    end else begin
      master_clear_pin_cnt_d = master_clear_pin_cnt_q + 8'h01;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      master_clear_pin_s1_q <= 1'b1;
      master_clear_pin_s2_q <= 1'b1;
      master_clear_pin_cnt_q <= 8'h00;
      master_clear_pin_rst_q <= 1'b0;
    end else begin
      master_clear_pin_s1_q <= master_clear_pin_n;
      master_clear_pin_s2_q <= master_clear_pin_s1_q;
      master_clear_pin_cnt_q <= master_clear_pin_cnt_d;
      master_clear_pin_rst_q <= master_clear_pin_rst_d;
    end
  end

  // cause register: hardware sets win over same-cycle software writes
  assign hw_set[`RCS_B_TRAP] = trap_conflict;
  assign hw_set[`RCS_B_ILL] = illegal_condition;
  assign hw_set[13:10] = 4'h0;
  assign hw_set[`RCS_B_CM] = config_mismatch;
  assign hw_set[`RCS_B_VREG] = 1'b0;
  assign hw_set[`RCS_B_EXT] = master_clear_pin_rst_q;
  assign hw_set[`RCS_B_SW] = soft_reset_req;
  assign hw_set[`RCS_B_WDEN] = 1'b0;
  assign hw_set[`RCS_B_WATCHDOG_TIMEOUT_FLAG] = watchdog_timeout;
  assign hw_set[`RCS_B_SLP] = sleep_entry;
  assign hw_set[`RCS_B_IDL] = idle_entry;
  assign hw_set[`RCS_B_BOR] = 1'b0;
  assign hw_set[`RCS_B_POR] = 1'b0;

  // brown-out keeps only pin flag and the control bits, then marks itself
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_cause
      wire wr_val = is_write ? (reg_wdata[gi] & cause_mask[gi]) : cause_q[gi];
      wire set_val = wr_val | hw_set[gi];
      wire bor_val = (set_val & bor_keep[gi]) | (gi == `RCS_B_BOR);
      assign cause_d[gi] = brownout_low ? bor_val : set_val;
    end
  endgenerate

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cause_q <= `RCS_CAUSE_POR_VAL;
    end else begin
      cause_q <= cause_d;
    end
  end

  // sequencer: a supply dip always wins, a warm source only once running
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    warm_d = warm_q;
    osc_d = current_osc_select;
    fetch_start_d = 1'b0;
    if (brownout_low) begin
      state_d = S_BOR;
      cnt_d = 32'h0;
      warm_d = 1'b0;
    end else if (warm_src && state_q == S_RUN) begin
      state_d = S_OST;
      cnt_d = 32'h0;
      warm_d = 1'b1;
    end else begin
      case (state_q)
        S_POR: begin
          cnt_d = cnt_q + 32'h1;
          if (cnt_q >= POWERON_EXTENSION_DELAY_CYC - 1) begin
            state_d = S_POWERUP_TIMER;
            cnt_d = 32'h0;
          end
        end
        S_BOR: begin
          cnt_d = cnt_q + 32'h1;
          if (cnt_q >= BROWNOUT_EXTENSION_DELAY_CYC - 1) begin
            state_d = S_POWERUP_TIMER;
            cnt_d = 32'h0;
          end
        end
        S_POWERUP_TIMER: begin
          cnt_d = cnt_q + 32'h1;
          if (cnt_q >= powerup_timer_cyc) begin
            state_d = S_OST;
            cnt_d = 32'h0;
          end
        end
        S_OST: begin
          if (!is_xtal) begin
            state_d = S_LOCK;
            cnt_d = 32'h0;
          end else if (osc_tick) begin
            cnt_d = cnt_q + 32'h1;
            if (cnt_q == `RCS_TOST_CLKS - 1) begin
              state_d = S_LOCK;
              cnt_d = 32'h0;
            end
          end
        end
        S_LOCK: begin
          cnt_d = cnt_q + 32'h1;
          // a source still held keeps the core parked here
          if ((!is_pll || cnt_q >= PLL_LOCK_TIME_CYC - 1) && !warm_src) begin
            state_d = S_RUN;
            osc_d = osc_sel;
            fetch_start_d = 1'b1;
          end
        end
        S_RUN: begin
          state_d = S_RUN;
        end
        default: begin
          state_d = S_POR;
        end
      endcase
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= S_POR;
      cnt_q <= 32'h0;
      warm_q <= 1'b0;
      current_osc_select <= 3'h0;
      fetch_start <= 1'b0;
      fetch_addr <= 24'h000000;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      warm_q <= warm_d;
      current_osc_select <= osc_d;
      fetch_start <= fetch_start_d;
      if (fetch_start_d)
        fetch_addr <= `RCS_RESET_VECTOR;
    end
  end

  // clock monitor start delay, restarted by any reset or by disabling it
  always @* begin
    fail_safe_clock_monitor_d = fail_safe_clock_monitor_q;
    fail_safe_clock_monitor_active_d = clock_monitor_active;
    if (state_q != S_RUN || !clock_monitor_enable) begin
      fail_safe_clock_monitor_d = 32'h0;
      fail_safe_clock_monitor_active_d = 1'b0;
    end else if (fail_safe_clock_monitor_q >= CLOCK_MONITOR_START_DELAY_CYC - 1) begin
      fail_safe_clock_monitor_active_d = 1'b1;
    end else begin
      fail_safe_clock_monitor_d = fail_safe_clock_monitor_q + 32'h1;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fail_safe_clock_monitor_q <= 32'h0;
      clock_monitor_active <= 1'b0;
    end else begin
      fail_safe_clock_monitor_q <= fail_safe_clock_monitor_d;
      clock_monitor_active <= fail_safe_clock_monitor_active_d;
    end
  end

  // register read, data one cycle later and zero otherwise
  always @* begin
    rdata_d = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `RCS_ADDR_CAUSE: begin
          rdata_d = cause_q;
        end
        `RCS_ADDR_OSC: begin
          rdata_d = {13'h0, current_osc_select};
        end
        `RCS_ADDR_STAT: begin
          rdata_d = {10'h0, state_q};
        end
        default: begin
          rdata_d = 16'h0000;
        end
      endcase
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= rdata_d;
    end
  end
endmodule // rcs_reset_seq

// File: sim/rcs_monitor.sv
// assertion checker bound to the reset cause and sequencer
`timescale 1ns/1ps
module rcs_monitor (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // sources
  input wire brownout_low,
  input wire master_clear_pin_n,
  input wire soft_reset_req,
  input wire watchdog_timeout,
  input wire config_mismatch,
  input wire sleep_entry,
  input wire watchdog_fuse_enable,
  // register port
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  // outputs
  input wire system_reset_line,
  input wire watchdog_enable,
  input wire regulator_active_in_sleep,
  input wire fetch_start,
  input wire [23:0] fetch_addr
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire warm_src = soft_reset_req | watchdog_timeout | config_mismatch | brownout_low;
  wire cause_wr = reg_wr && reg_addr == 4'h0;
  sequence quiet_write;
    cause_wr && !system_reset_line ##1 !warm_src && master_clear_pin_n;
  endsequence
  sequence sleep_then_read;
    sleep_entry ##1 !brownout_low ##1 (reg_rd && reg_addr == 4'h0 && !brownout_low);
  endsequence
  src_holds_reset_a: assert property (warm_src |-> system_reset_line)
    else $error("reset line low with a source active");
  write_no_reset_a: assert property (quiet_write |-> !system_reset_line)
    else $error("register write caused a reset");
  fetch_pulse_a: assert property (fetch_start |=> !fetch_start)
    else $error("fetch start longer than one cycle");
  fetch_vector_a: assert property (fetch_start |-> fetch_addr == 24'h000000)
    else $error("fetch not at reset address");
  fuse_wd_a: assert property (watchdog_fuse_enable |-> watchdog_enable)
    else $error("fuse did not force watchdog on");
  soft_wd_a: assert property (cause_wr && reg_wdata[5] |=> watchdog_enable)
    else $error("soft enable ignored");
  standby_ctl_a: assert property (cause_wr |=>
    regulator_active_in_sleep == $past(reg_wdata[8])) else $error("standby control wrong");
  sleep_flag_a: assert property (sleep_then_read |=> reg_rdata[3])
    else $error("sleep flag not set");
endmodule // rcs_monitor
bind rcs_reset_seq rcs_monitor mon (.*);

// File: sim/rcs_supervisor.sv
// model of the external supervisor on the master clear pin
`timescale 1ns/1ps
module rcs_supervisor (
  // clock
  input wire ref_clk,
  // request
  input wire go,
  input wire [7:0] low_cycles,
  // pin
  output reg master_clear_pin_n
);
  reg [7:0] cnt_q = 8'h00;
  initial master_clear_pin_n = 1'b1;
  // pin sits high as if tied to supply, never floats
  always @(posedge ref_clk) begin
    if (go) begin
      cnt_q <= low_cycles;
      master_clear_pin_n <= 1'b0;
    end else if (cnt_q > 8'h01) begin
      cnt_q <= cnt_q - 8'h01;
    end else begin
      master_clear_pin_n <= 1'b1;
    end
  end
endmodule // rcs_supervisor

// File: sim/tb.sv
// self-checking bench for the reset cause and sequencer
`timescale 1ns/1ps
`include "rcs_map.vh"
module tb;
  reg ref_clk = 1'b0, rst = 1'b1, brownout_low = 1'b0, osc_tick = 1'b0;
  reg watchdog_fuse_enable = 1'b0, clock_monitor_enable = 1'b1, go = 1'b0;
  reg reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
  reg [2:0] initial_osc_select = `RCS_MODE_XTPLL, powerup_delay_select = 3'h1;
  reg [3:0] reg_addr = 4'h0;
  reg [15:0] reg_wdata = 16'h0000;
  reg [6:0] ev = 7'h00;
  reg [7:0] low_len = 8'h00;
  wire soft_reset_req, watchdog_timeout, config_mismatch, trap_conflict;
  wire illegal_condition, sleep_entry, idle_entry, master_clear_pin_n;
  wire system_reset_line, watchdog_enable, regulator_active_in_sleep;
  wire fetch_start, clock_monitor_active;
  wire [2:0] current_osc_select;
  wire [15:0] reg_rdata;
  wire [23:0] fetch_addr;
  logic [15:0] exp_q[$];
  logic [31:0] rng = 32'd47554;
  int failures = 0, num_checks = 0;
  int pos[7] = '{6, 4, 9, 15, 14, 3, 2};
  assign {idle_entry, sleep_entry, illegal_condition, trap_conflict, config_mismatch,
    watchdog_timeout, soft_reset_req} = ev;
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) osc_tick <= ~osc_tick;
  rcs_reset_seq #(.POWERON_EXTENSION_DELAY_CYC(8), .BROWNOUT_EXTENSION_DELAY_CYC(8), .PLL_LOCK_TIME_CYC(8), .CLOCK_MONITOR_START_DELAY_CYC(8),
    .POWERUP_TIMER_UNIT_CYC(2), .MASTER_CLEAR_PIN_FILT_CYC(4)) dut (.*);
  rcs_supervisor sup (.ref_clk(ref_clk), .go(go), .low_cycles(low_len),
    .master_clear_pin_n(master_clear_pin_n));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask
  // bounded wait for the release pulse
  task automatic wait_run;
    int n;
    n = 0;
    while (fetch_start !== 1'b1 && n < 4000) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk("fetch_addr", fetch_addr, 24'h000000);
    chk("released", n < 4000, 1'b1);
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    rd_seen <= reg_rd;
    if (rd_seen) chk("reg_rdata", reg_rdata, exp_q.pop_front());
  end
  initial begin
    repeat (40000) @(posedge ref_clk);
    failures++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    wait_run();
    chk("clock_monitor", clock_monitor_active, 1'b0);
    rd(4'h0, 16'h0003);
    $display("test power_on done");
    for (int i = 0; i < 8; i++) begin
      rng = xs(rng);
      wr(4'h0, rng[15:0]);
      rd(4'h0, rng[15:0] & 16'hC3FF);
      chk("watchdog_enable", watchdog_enable, rng[5]);
      chk("regulator", regulator_active_in_sleep, rng[8]);
    end
    wr(4'h2, 16'hFFFF);
    rd(4'h3, 16'h0000);
    watchdog_fuse_enable <= 1'b1;
    wr(4'h0, 16'h0000);
    chk("watchdog_enable", watchdog_enable, 1'b1);
    watchdog_fuse_enable <= 1'b0;
    chk("clock_monitor", clock_monitor_active, 1'b1);
    $display("test register done");
    // cold-only select: a warm reset must not pick it up
    initial_osc_select <= `RCS_MODE_XT;
    for (int i = 0; i < 7; i++) begin
      wr(4'h0, 16'h0000);
      @(posedge ref_clk) ev[i] <= 1'b1;
      @(posedge ref_clk) ev <= 7'h00;
      if (i < 5) wait_run();
      rd(4'h0, 16'h0001 << pos[i]);
      chk("osc_select", current_osc_select, `RCS_MODE_XTPLL);
    end
    $display("test events done");
    clock_monitor_enable <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      wr(4'h0, 16'h0000);
      @(posedge ref_clk) go <= 1'b1;
      low_len <= i ? 8'h0C : 8'h02;
      @(posedge ref_clk) go <= 1'b0;
      if (i) wait_run();
      else repeat (20) @(posedge ref_clk);
      rd(4'h0, i ? 16'h0080 : 16'h0000);
    end
    repeat (12) @(posedge ref_clk);
    chk("clock_monitor", clock_monitor_active, 1'b0);
    clock_monitor_enable <= 1'b1;
    $display("test master_clear done");
    powerup_delay_select <= 3'h3;
    wr(4'h0, 16'h01A0);
    @(posedge ref_clk) brownout_low <= 1'b1;
    repeat (3) @(posedge ref_clk);
    brownout_low <= 1'b0;
    wait_run();
    rd(4'h0, 16'h01A2);
    chk("osc_select", current_osc_select, `RCS_MODE_XT);
    repeat (12) @(posedge ref_clk);
    chk("clock_monitor", clock_monitor_active, 1'b1);
    $display("test brownout done");
    repeat (2) @(posedge ref_clk);
    report_and_stop();
  end
endmodule // tb
